// ---- pkg/sscd_consts.vh ----
// Register map, field positions and reset values of the stage config decoder
`ifndef SSCD_CONSTS_VH
`define SSCD_CONSTS_VH

// -----------------------------------------------------------------------------
// Register map (byte addresses; offsets within a stage count words)
// -----------------------------------------------------------------------------
`define SSCD_STAGE_STRIDE   12'h010
`define SSCD_ROUTE_LO_OFS   2'h0
`define SSCD_ROUTE7_OFS     2'h1
`define SSCD_OFFSET_OFS     2'h2
`define SSCD_SENS_OFS       2'h3
`define SSCD_STATUS_ADDR    12'h080
`define SSCD_LAST_CFG_ADDR  12'h07C

// -----------------------------------------------------------------------------
// Writable bit masks (reserved bits read zero)
// -----------------------------------------------------------------------------
`define SSCD_ROUTE_LO_MASK  16'h3FFF
`define SSCD_ROUTE7_MASK    16'hF003
`define SSCD_OFFSET_MASK    16'hBFBF
`define SSCD_SENS_MASK      16'h7F7F
`define SSCD_CFG_RESET      16'h0000

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define SSCD_E7_ROUTE       1:0
`define SSCD_MODE_SEL       13:12
`define SSCD_MINUS_OFF_BIT  14
`define SSCD_PLUS_OFF_BIT   15
`define SSCD_MINUS_MAG      5:0
`define SSCD_MINUS_STEER    7
`define SSCD_PLUS_MAG       13:8
`define SSCD_PLUS_STEER     15
`define SSCD_MINUS_THR      3:0
`define SSCD_MINUS_PEAK     6:4
`define SSCD_PLUS_THR       11:8
`define SSCD_PLUS_PEAK      14:12

// -----------------------------------------------------------------------------
// Encodings
// -----------------------------------------------------------------------------
`define SSCD_ROUTE_OPEN     2'h0
`define SSCD_ROUTE_MINUS    2'h1
`define SSCD_ROUTE_PLUS     2'h2
`define SSCD_ROUTE_BIAS     2'h3
`define SSCD_MODE_BAD       2'h0
`define SSCD_MODE_SE_PLUS   2'h1
`define SSCD_MODE_SE_MINUS  2'h2
`define SSCD_MODE_DIFF      2'h3
`define SSCD_PEAK_LAST      3'h5
`define SSCD_PEAK_BASE      7'h28
`define SSCD_PEAK_STEP      7'h0A

`endif

// ---- logic/sscd_top.v ----
// Per-stage sensing configuration store and decoder with APB access
`timescale 1ns/1ps
// Overview of operation
// [R1] Decode electrode 7 route: open, minus, plus, bias
// [R2] Software zeroes unused electrode-7 word bits
// [R3] Mode field: single-ended plus/minus, differential
// [R4] Bit 14 low enables minus offset
// [R5] Bit 15 low enables plus offset
// [R6] Minus offset magnitude from bits 5:0
// [R7] Bit 7 steers minus offset to plus
// [R8] Plus offset magnitude from bits 13:8
// [R9] Bit 15 steers plus offset to minus
// [R10] Minus threshold code maps to percentage
// [R11] Minus peak level 40 to 90 percent
// [R12] Plus threshold same percentage mapping
// [R13] Plus peak level 40 to 90 percent
// [R14] Eight independent stage copies of words
// [R15] Electrodes 0..6 routed with same encoding
// [R16] Software avoids bad peak codes, reserved bits
`include "sscd_consts.vh"

module sscd_top #(
    parameter integer STAGES = 8,      // Sequencer stages
    parameter integer INPUTS = 8       // Electrode inputs
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // Sequencer side
    input  wire [2:0]  stage_sel_i,
    // Electrode switch matrix, one bit per electrode
    output reg  [7:0]  elec_to_minus_o,
    output reg  [7:0]  elec_to_plus_o,
    output reg  [7:0]  elec_to_bias_o,
    // Measurement mode
    output reg         mode_se_plus_o,
    output reg         mode_se_minus_o,
    output reg         mode_diff_o,
    output reg         mode_bad_o,
    // Offset injection
    output reg         minus_offset_en_o,
    output reg  [5:0]  minus_offset_magnitude_o,
    output reg         minus_offset_on_plus_o,
    output reg         plus_offset_en_o,
    output reg  [5:0]  plus_offset_magnitude_o,
    output reg         plus_offset_on_minus_o,
    // Threshold levels, hundredths of a percent
    output reg  [13:0] minus_threshold_level_o,
    output reg  [13:0] plus_threshold_level_o,
    // Peak levels in percent, zero on an undefined code
    output reg  [6:0]  minus_peak_level_o,
    output reg  [6:0]  plus_peak_level_o,
    output reg         peak_code_bad_o
);

    // -------------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------------
    // Cleared by reset: every electrode starts open, mode reads as forbidden
    reg  [15:0] route_lo_q [0:STAGES-1];   // Electrodes 0..6 routes
    reg  [15:0] route7_q   [0:STAGES-1];   // Electrode 7, mode, offset enables
    reg  [15:0] offset_q   [0:STAGES-1];   // Offset magnitudes and steering
    reg  [15:0] sens_q     [0:STAGES-1];   // Threshold and peak selections

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    // Zero wait states: the answer is prepared in the setup cycle and shown
    // for exactly one access cycle. Writes land on the completing edge only,
    // so a setup that is never completed leaves storage alone.
    // Stage words fill the map up to the last word on word boundaries.
    wire        setup_w   = psel & ~penable;          // First APB cycle
    wire        access_w  = psel & penable & pready;  // Completing edge
    wire        cfg_hit_w = (paddr <= `SSCD_LAST_CFG_ADDR) & (paddr[1:0] == 2'h0);
    wire        sts_hit_w = (paddr == `SSCD_STATUS_ADDR);
    wire [2:0]  a_stage_w = paddr[6:4];               // Stage of the word
    wire [1:0]  a_word_w  = paddr[3:2];               // Word in the stage
    wire        wr_w      = access_w & pwrite & cfg_hit_w;

    // Selected stage words
    wire [15:0] s_lo_w  = route_lo_q[stage_sel_i];
    wire [15:0] s_r7_w  = route7_q[stage_sel_i];
    wire [15:0] s_ofs_w = offset_q[stage_sel_i];
    wire [15:0] s_sns_w = sens_q[stage_sel_i];

    // -------------------------------------------------------------------------
    // Fields of the selected stage
    // -------------------------------------------------------------------------
    // Codes are pulled out once so that the decode and the fault flags
    // always look at the same bits of the same stage word.
    wire [1:0]  mode_code_w  = s_r7_w[`SSCD_MODE_SEL];      // Measurement mode code
    wire [2:0]  minus_pk_w   = s_sns_w[`SSCD_MINUS_PEAK];   // Minus peak code
    wire [2:0]  plus_pk_w    = s_sns_w[`SSCD_PLUS_PEAK];    // Plus peak code
    wire [3:0]  minus_thr_w  = s_sns_w[`SSCD_MINUS_THR];    // Minus threshold code
    wire [3:0]  plus_thr_w   = s_sns_w[`SSCD_PLUS_THR];     // Plus threshold code
    // Either peak code beyond the last defined step  [R11] [R13]
    wire        peak_bad_w   = (minus_pk_w > `SSCD_PEAK_LAST) | (plus_pk_w > `SSCD_PEAK_LAST);

    // Threshold percentage table in hundredths
    // Fixed-point levels, so the calibration side needs no divider
    function [13:0] thr_pct;
        input [3:0] code;
        begin
            case (code)
                4'h0:    thr_pct = 14'h09C4;  // 25.00
                4'h1:    thr_pct = 14'h0B9D;  // 29.73
                4'h2:    thr_pct = 14'h0D70;  // 34.40
                4'h3:    thr_pct = 14'h0F44;  // 39.08
                4'h4:    thr_pct = 14'h111B;  // 43.79
                4'h5:    thr_pct = 14'h12F0;  // 48.48
                4'h6:    thr_pct = 14'h14C3;  // 53.15
                4'h7:    thr_pct = 14'h1697;  // 57.83
                4'h8:    thr_pct = 14'h186B;  // 62.51
                4'h9:    thr_pct = 14'h1A42;  // 67.22
                4'hA:    thr_pct = 14'h1C16;  // 71.90
                4'hB:    thr_pct = 14'h1DEA;  // 76.58
                4'hC:    thr_pct = 14'h1FC0;  // 81.28
                4'hD:    thr_pct = 14'h2194;  // 85.96
                4'hE:    thr_pct = 14'h2368;  // 90.64
                default: thr_pct = 14'h253C;  // 95.32
            endcase
        end
    endfunction

    // Peak level in percent; undefined codes give zero
    // Base level plus one step per code
    function [6:0] peak_pct;
        input [2:0] code;
        begin
            if (code <= `SSCD_PEAK_LAST) begin
                peak_pct = `SSCD_PEAK_BASE + `SSCD_PEAK_STEP * {4'h0, code};
            end else begin
                peak_pct = 7'h00;
            end
        end
    endfunction

    // -------------------------------------------------------------------------
    // Per-stage register write, one copy per stage
    // -------------------------------------------------------------------------
    genvar gs;
    generate
        for (gs = 0; gs < STAGES; gs = gs + 1) begin : g_stage
            // Each stage owns its words; only the addressed stage and word
            // change, so a sequencer running other stages sees no glitch.
            // Reserved bits are cleared on the way in and read back as zero.
            // Word write, reserved bits dropped  [R14]
            always @(posedge clk_sys_i) begin
                if (!rst_n_i) begin
                    route_lo_q[gs] <= `SSCD_CFG_RESET;
                    route7_q[gs]   <= `SSCD_CFG_RESET;
                    offset_q[gs]   <= `SSCD_CFG_RESET;
                    sens_q[gs]     <= `SSCD_CFG_RESET;
                end else if (wr_w && (a_stage_w == gs)) begin
                    case (a_word_w)
                        `SSCD_ROUTE_LO_OFS: begin
                            // Electrodes 0..6, top two bits unused
                            route_lo_q[gs] <= pwdata[15:0] & `SSCD_ROUTE_LO_MASK;
                        end
                        `SSCD_ROUTE7_OFS: begin
                            // Unused middle bits forced zero  [R2]
                            route7_q[gs] <= pwdata[15:0] & `SSCD_ROUTE7_MASK;
                        end
                        `SSCD_OFFSET_OFS: begin
                            // Reserved bits 6 and 14 dropped  [R16]
                            offset_q[gs] <= pwdata[15:0] & `SSCD_OFFSET_MASK;
                        end
                        default: begin
                            // Undefined peak codes kept as written
                            sens_q[gs] <= pwdata[15:0] & `SSCD_SENS_MASK;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Electrode route decode, one slice per electrode
    // -------------------------------------------------------------------------
    // Electrodes 0..6 take their codes from the low routing word, electrode
    // 7 from the bottom of its own word; the decode itself is shared.
    wire [7:0] to_minus_w;                     // Next electrode-to-minus
    wire [7:0] to_plus_w;                      // Next electrode-to-plus
    wire [7:0] to_bias_w;                      // Next electrode-to-bias
    genvar ge;
    generate
        for (ge = 0; ge < INPUTS; ge = ge + 1) begin : g_elec
            wire [1:0] code_w;
            if (ge < INPUTS - 1) begin : g_lo
                assign code_w = s_lo_w[2*ge+1:2*ge];          // [R15]
            end else begin : g_e7
                assign code_w = s_r7_w[`SSCD_E7_ROUTE];       // [R1]
            end
            assign to_minus_w[ge] = (code_w == `SSCD_ROUTE_MINUS);
            assign to_plus_w[ge]  = (code_w == `SSCD_ROUTE_PLUS);
            assign to_bias_w[ge]  = (code_w == `SSCD_ROUTE_BIAS);
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Decoded outputs, registered
    // -------------------------------------------------------------------------
    // Every decoded output is a flop: the switches see one clean edge per
    // change of stage or of stored word, one cycle later.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            elec_to_minus_o          <= 8'h00;
            elec_to_plus_o           <= 8'h00;
            elec_to_bias_o           <= 8'h00;
            mode_se_plus_o           <= 1'b0;
            mode_se_minus_o          <= 1'b0;
            mode_diff_o              <= 1'b0;
            mode_bad_o               <= 1'b0;
            minus_offset_en_o        <= 1'b0;
            minus_offset_magnitude_o <= 6'h00;
            minus_offset_on_plus_o   <= 1'b0;
            plus_offset_en_o         <= 1'b0;
            plus_offset_magnitude_o  <= 6'h00;
            plus_offset_on_minus_o   <= 1'b0;
            minus_threshold_level_o  <= 14'h0000;
            plus_threshold_level_o   <= 14'h0000;
            minus_peak_level_o       <= 7'h00;
            plus_peak_level_o        <= 7'h00;
            peak_code_bad_o          <= 1'b0;
        end else begin
            // Switch matrix  [R1] [R15]
            elec_to_minus_o <= to_minus_w;
            elec_to_plus_o  <= to_plus_w;
            elec_to_bias_o  <= to_bias_w;
            // Mode, code 00 flagged as forbidden  [R3]
            mode_se_plus_o  <= (mode_code_w == `SSCD_MODE_SE_PLUS);
            mode_se_minus_o <= (mode_code_w == `SSCD_MODE_SE_MINUS);
            mode_diff_o     <= (mode_code_w == `SSCD_MODE_DIFF);
            mode_bad_o      <= (mode_code_w == `SSCD_MODE_BAD);
            // Offset enables are active-low disables  [R4] [R5]
            minus_offset_en_o <= ~s_r7_w[`SSCD_MINUS_OFF_BIT];
            plus_offset_en_o  <= ~s_r7_w[`SSCD_PLUS_OFF_BIT];
            // Offset magnitudes, 0.32 pF per step  [R6] [R8]
            minus_offset_magnitude_o <= s_ofs_w[`SSCD_MINUS_MAG];
            plus_offset_magnitude_o  <= s_ofs_w[`SSCD_PLUS_MAG];
            // Offset steering  [R7] [R9]
            minus_offset_on_plus_o <= s_ofs_w[`SSCD_MINUS_STEER];
            plus_offset_on_minus_o <= s_ofs_w[`SSCD_PLUS_STEER];
            // Threshold percentages  [R10] [R12]
            minus_threshold_level_o <= thr_pct(minus_thr_w);
            plus_threshold_level_o  <= thr_pct(plus_thr_w);
            // Peak levels, undefined codes flagged  [R11] [R13]
            minus_peak_level_o <= peak_pct(minus_pk_w);
            plus_peak_level_o  <= peak_pct(plus_pk_w);
            peak_code_bad_o    <= peak_bad_w;
        end
    end

    // -------------------------------------------------------------------------
    // Read mux for the addressed word
    // -------------------------------------------------------------------------
    // Read data is the stored, masked word, so software reads back exactly
    // what the decoder acts on. Addresses outside the map read zero.
    reg [15:0] rd_word_w;                       // Addressed word value
    always @* begin
        rd_word_w = 16'h0000;
        if (cfg_hit_w) begin
            case (a_word_w)
                `SSCD_ROUTE_LO_OFS: rd_word_w = route_lo_q[a_stage_w];
                `SSCD_ROUTE7_OFS:   rd_word_w = route7_q[a_stage_w];
                `SSCD_OFFSET_OFS:   rd_word_w = offset_q[a_stage_w];
                default:            rd_word_w = sens_q[a_stage_w];
            endcase
        end else if (sts_hit_w) begin
            // Live stage and fault flags
            rd_word_w = {11'h000, peak_code_bad_o, mode_bad_o, stage_sel_i};
        end
    end

    // -------------------------------------------------------------------------
    // APB answer: captured in setup, shown for one access cycle
    // -------------------------------------------------------------------------
    // The error flag rides with ready; a refused write has already been kept
    // out of storage by the address check in the write enable.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_w) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : {16'h0000, rd_word_w};
            // Unmapped, or a write to the read-only status word
            pslverr <= ~(cfg_hit_w | (sts_hit_w & ~pwrite));
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

endmodule

// ---- tb/sscd_top_properties.sv ----
// Port-level assertions for the stage configuration decoder
`timescale 1ns/1ps
module sscd_top_properties (
    // Clock, reset and APB answer
    input wire        clk_sys_i,
    input wire        rst_n_i,
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Decoded stage outputs
    input wire [7:0]  elec_to_minus_o,
    input wire [7:0]  elec_to_plus_o,
    input wire [7:0]  elec_to_bias_o,
    input wire        mode_se_plus_o,
    input wire        mode_se_minus_o,
    input wire        mode_diff_o,
    input wire        mode_bad_o,
    input wire [13:0] minus_threshold_level_o,
    input wire [13:0] plus_threshold_level_o,
    input wire [6:0]  minus_peak_level_o,
    input wire [6:0]  plus_peak_level_o,
    input wire        peak_code_bad_o
);
    // One clock domain for every property
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_ROUTE_EXCL: assert property (((elec_to_minus_o & elec_to_plus_o) |
        (elec_to_bias_o & (elec_to_minus_o | elec_to_plus_o))) == 8'h00)
        else $error("electrode routed two ways");
    AST_MODE_ONEHOT: assert property ($past(rst_n_i) |->
        $onehot({mode_se_plus_o, mode_se_minus_o, mode_diff_o, mode_bad_o}))
        else $error("mode outputs not one-hot");
    AST_THR_RANGE: assert property ($past(rst_n_i) |->
        minus_threshold_level_o >= 14'h09C4 && minus_threshold_level_o <= 14'h253C &&
        plus_threshold_level_o >= 14'h09C4 && plus_threshold_level_o <= 14'h253C)
        else $error("threshold level out of range");
    AST_MINUS_PEAK: assert property (minus_peak_level_o == 7'h00 ||
        (minus_peak_level_o >= 7'h28 && minus_peak_level_o <= 7'h5A &&
        minus_peak_level_o % 7'h0A == 7'h00)) else $error("minus peak level not a step");
    AST_PLUS_PEAK: assert property (plus_peak_level_o == 7'h00 ||
        (plus_peak_level_o >= 7'h28 && plus_peak_level_o <= 7'h5A &&
        plus_peak_level_o % 7'h0A == 7'h00)) else $error("plus peak level not a step");
    AST_PEAK_FLAG: assert property ($past(rst_n_i) |-> peak_code_bad_o ==
        (minus_peak_level_o == 7'h00 || plus_peak_level_o == 7'h00))
        else $error("peak flag disagrees with levels");
    AST_READY_SETUP: assert property (pready == $past(psel && !penable))
        else $error("ready not in cycle after setup");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
    AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("bus answer outside access cycle");
    // Main scenarios seen
    cover property (pready && pslverr);
    cover property (mode_diff_o);
    cover property (peak_code_bad_o);
endmodule

// ---- tb/sscd_top_tb.sv ----
// Self-checking bench for the stage configuration decoder
`timescale 1ns/1ps
module sscd_top_tb;
    localparam logic [13:0] THR [16] = '{14'h09C4, 14'h0B9D, 14'h0D70, 14'h0F44, 14'h111B,
        14'h12F0, 14'h14C3, 14'h1697, 14'h186B, 14'h1A42, 14'h1C16, 14'h1DEA, 14'h1FC0,
        14'h2194, 14'h2368, 14'h253C}; // Threshold levels, hundredths of a percent
    reg         clk_sys_i = 1'b0;   // System clock
    reg         rst_n_i = 1'b0;     // Synchronous reset
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [2:0]  stage_sel_i = 3'h0;
    wire        pready, pslverr, mode_se_plus_o, mode_se_minus_o, mode_diff_o, mode_bad_o;
    wire [31:0] prdata;
    wire [7:0]  elec_to_minus_o, elec_to_plus_o, elec_to_bias_o;
    wire        minus_offset_en_o, minus_offset_on_plus_o, plus_offset_en_o;
    wire        plus_offset_on_minus_o, peak_code_bad_o;
    wire [5:0]  minus_offset_magnitude_o, plus_offset_magnitude_o;
    wire [13:0] minus_threshold_level_o, plus_threshold_level_o;
    wire [6:0]  minus_peak_level_o, plus_peak_level_o;
    reg  [15:0] mem [0:31];         // Expected register contents
    reg  [33:0] q [$];              // Notes: write flag, error, data
    reg  [33:0] e;
    reg  [15:0] lo, r7, of, se;
    reg  [7:0]  em, ep, eb;
    reg  [1:0]  c;
    integer     i, k, j, n_fail = 0, samples_checked = 0;
    sscd_top i_sscd_top (.clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .stage_sel_i, .elec_to_minus_o, .elec_to_plus_o,
        .elec_to_bias_o, .mode_se_plus_o, .mode_se_minus_o, .mode_diff_o, .mode_bad_o,
        .minus_offset_en_o, .minus_offset_magnitude_o, .minus_offset_on_plus_o,
        .plus_offset_en_o, .plus_offset_magnitude_o, .plus_offset_on_minus_o,
        .minus_threshold_level_o, .plus_threshold_level_o, .minus_peak_level_o,
        .plus_peak_level_o, .peak_code_bad_o);
    // 40 MHz clock
    always #12.5 clk_sys_i = ~clk_sys_i;
    // Compare seen against expected
    task check(input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts, verdict, end of run
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One APB transfer, answer noted for the monitor
    task apb(input wr, input [11:0] a, input [31:0] d, input [31:0] ex, input er);
        q.push_back({wr, er, ex});
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write with model update, writable bits only
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
        mem[a[6:2]] = d[15:0] & (a[3:2] == 2'h0 ? 16'h3FFF : a[3:2] == 2'h1 ? 16'hF003 :
            a[3:2] == 2'h2 ? 16'hBFBF : 16'h7F7F);
    endtask
    task rd(input [11:0] a);
        apb(1'b0, a, 32'h0, {16'h0000, mem[a[6:2]]}, 1'b0);
    endtask
    function [6:0] pk(input [2:0] cd);
        pk = (cd > 3'h5) ? 7'h00 : 7'h28 + 7'h0A * cd;
    endfunction
    // Select a stage and compare every decoded output
    task dchk(input [2:0] s);
        stage_sel_i <= s;
        repeat (2) @(posedge clk_sys_i);
        #1;
        {lo, r7, of, se} = {mem[{s, 2'h0}], mem[{s, 2'h1}], mem[{s, 2'h2}], mem[{s, 2'h3}]};
        for (j = 0; j < 8; j = j + 1) begin
            c = (j == 7) ? r7[1:0] : lo[2*j+:2];
            {em[j], ep[j], eb[j]} = {c == 2'h1, c == 2'h2, c == 2'h3};
        end
        check({elec_to_minus_o, elec_to_plus_o, elec_to_bias_o}, {em, ep, eb});
        check({mode_diff_o, mode_se_minus_o, mode_se_plus_o, mode_bad_o}, 1 << r7[13:12]);
        check({plus_offset_en_o, minus_offset_en_o}, {~r7[15], ~r7[14]});
        check({minus_offset_on_plus_o, minus_offset_magnitude_o}, {of[7], of[5:0]});
        check({plus_offset_on_minus_o, plus_offset_magnitude_o}, {of[15], of[13:8]});
        check({minus_threshold_level_o, plus_threshold_level_o},
            {THR[se[3:0]], THR[se[11:8]]});
        check({minus_peak_level_o, plus_peak_level_o}, {pk(se[6:4]), pk(se[14:12])});
        check(peak_code_bad_o, se[6:5] == 2'h3 || se[14:13] == 2'h3);
    endtask
    // Monitor: each answer against the oldest note
    always @(posedge clk_sys_i) begin
        if (pready === 1'b1) begin
            e = q.pop_front();
            check(pslverr, e[32]);
            if (!e[33]) check(prdata, e[31:0]);
        end
    end
    // Watchdog, far beyond the few hundred cycles the tests take
    initial begin
        #500000;
        n_fail = n_fail + 1;
        complete_run;
    end
    // Main sequence
    initial begin
        void'($urandom(32'h8167));
        for (i = 0; i < 32; i = i + 1) mem[i] = 16'h0000;
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 32; i = i + 1) rd(i * 4);
        dchk(3'h0);
        $display("test reset values done");
        for (i = 0; i < 32; i = i + 1) wr(i * 4, $urandom);
        for (i = 0; i < 32; i = i + 1) rd(i * 4);
        for (i = 0; i < 8; i = i + 1) dchk(i);
        $display("test stage copies done");
        for (k = 0; k < 16; k = k + 1) begin
            wr(12'h054, {k[3:2], k[1:0], 10'h000, ~k[1:0]});
            wr(12'h05C, {1'b0, k[2:0], 4'(15 - k), 1'b0, k[2:0], k[3:0]});
            dchk(3'h5);
        end
        $display("test code sweep done");
        apb(1'b0, 12'h002, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h046, 32'hFFFF, 32'h0, 1'b1);
        apb(1'b1, 12'h084, 32'hFFFF, 32'h0, 1'b1);
        apb(1'b1, 12'h080, 32'hFFFF, 32'h0, 1'b1);
        rd(12'h044);
        apb(1'b0, 12'h080, 32'h0, 32'h00000015, 1'b0);
        $display("test refused access done");
        // Reset in mid-run clears every stage again
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 32; i = i + 1) mem[i] = 16'h0000;
        for (i = 0; i < 32; i = i + 1) rd(i * 4);
        dchk(3'h5);
        $display("test mid-run reset done");
        complete_run;
    end
endmodule
bind sscd_top sscd_top_properties i_sscd_top_properties (.clk_sys_i, .rst_n_i, .psel,
    .penable, .pready, .prdata, .pslverr, .elec_to_minus_o, .elec_to_plus_o, .elec_to_bias_o,
    .mode_se_plus_o, .mode_se_minus_o, .mode_diff_o, .mode_bad_o, .minus_threshold_level_o,
    .plus_threshold_level_o, .minus_peak_level_o, .plus_peak_level_o, .peak_code_bad_o);
